// ==== core/fxd_defs.vh ====
// Constants for the floating-point exception detect block: operation codes,
// condition vector layout, control word fields, bus offsets and format limits.
// Assumes inclusion by bare name from the design files of the block that use it.
`ifndef FXD_DEFS_VH
`define FXD_DEFS_VH

// Operation codes presented by the datapath.
`define FXD_OP_ADD 4'h0
`define FXD_OP_SUB 4'h1
`define FXD_OP_MUL 4'h2
`define FXD_OP_DIV 4'h3
`define FXD_OP_SQRT 4'h4
`define FXD_OP_CMP 4'h5
`define FXD_OP_CVTF 4'h6
`define FXD_OP_CVTI 4'h7
`define FXD_OP_MOVE 4'h8
`define FXD_OP_XFER 4'h9
`define FXD_OP_ABS 4'ha
`define FXD_OP_NEG 4'hb

// Condition vector bit positions.
`define FXD_C_INEXACT 0
`define FXD_C_UNDER 1
`define FXD_C_OVER 2
`define FXD_C_DIVZ 3
`define FXD_C_INVALID 4
`define FXD_C_UNIMPL 5

// Rounding mode encodings.
`define FXD_RM_NEAREST 2'h0
`define FXD_RM_ZERO 2'h1
`define FXD_RM_PLUS 2'h2
`define FXD_RM_MINUS 2'h3

// Control/status word fields.
`define FXD_CSW_RM_LSB 0
`define FXD_CSW_FLAG_LSB 2
`define FXD_CSW_EN_LSB 7
`define FXD_CSW_CAUSE_LSB 12
`define FXD_CSW_IMPRECISE 24
`define FXD_CSW_RESET 32'h00000000

// Register byte offsets.
`define FXD_ADDR_CSW 4'h0
`define FXD_ADDR_STATUS 4'h4

// Format limits and default encodings.
`define FXD_EMAX_S 13'sd127
`define FXD_EMAX_D 13'sd1023
`define FXD_EMIN_S -13'sd126
`define FXD_EMIN_D -13'sd1022
`define FXD_INF_S 64'h000000007f800000
`define FXD_INF_D 64'h7ff0000000000000
`define FXD_MAXF_S 64'h000000007f7fffff
`define FXD_MAXF_D 64'h7fefffffffffffff
`define FXD_QNAN_S 64'h000000007fbfffff
`define FXD_QNAN_D 64'h7ff7ffffffffffff
`define FXD_SIGN_S 64'h0000000080000000
`define FXD_SIGN_D 64'h8000000000000000

`endif

// ==== core/fxd_classify.v ====
// Operand classifier: sorts one operand into zero, infinity and NaN classes.
// Assumes single values sit in the low 32 bits and double values fill all 64.
`timescale 1ns/10ps
`default_nettype none

module fxd_classify #(
    parameter SNAN_WHEN_SET = 1
) (
    input wire [63:0] val_i,
    input wire dbl_i,
    output wire sign_o,
    output wire zero_o,
    output wire inf_o,
    output wire nan_o,
    output wire snan_o
);
    wire exp_ones;
    wire exp_zero;
    wire frac_zero;
    wire qbit;

    // Field extraction for the two formats.
    assign sign_o = dbl_i ? val_i[63] : val_i[31];
    assign exp_ones = dbl_i ? (&val_i[62:52]) : (&val_i[30:23]);
    assign exp_zero = dbl_i ? ~(|val_i[62:52]) : ~(|val_i[30:23]);
    assign frac_zero = dbl_i ? ~(|val_i[51:0]) : ~(|val_i[22:0]);
    assign qbit = dbl_i ? val_i[51] : val_i[22];

    // Classes derived from the fields.
    assign zero_o = exp_zero & frac_zero;
    assign inf_o = exp_ones & frac_zero;
    assign nan_o = exp_ones & ~frac_zero;
    assign snan_o = nan_o & (SNAN_WHEN_SET != 0 ? qbit : ~qbit);
endmodule // fxd_classify

`default_nettype wire

// ==== core/fxd_default.v ====
// Default result selector for invalid, divide-by-zero and overflow conditions; fxd_top gates only overflow by its enable.
// Assumes the datapath result is correct whenever no condition overrides it.
`timescale 1ns/10ps
`default_nettype none
`include "fxd_defs.vh"

module fxd_default (
    input wire [63:0] res_i,
    input wire dbl_i,
    input wire sign_i,
    input wire [1:0] rm_i,
    input wire invalid_i,
    input wire divz_i,
    input wire over_i,
    output reg [63:0] res_o
);
    reg [63:0] inf_v;
    reg [63:0] maxf_v;
    reg [63:0] sgn_v;
    reg to_inf;

    // Picks a quiet NaN, a signed infinity, or the rounding-mode overflow value.
    always @*
    begin
        inf_v = dbl_i ? `FXD_INF_D : `FXD_INF_S;
        maxf_v = dbl_i ? `FXD_MAXF_D : `FXD_MAXF_S;
        sgn_v = sign_i ? (dbl_i ? `FXD_SIGN_D : `FXD_SIGN_S) : 64'h0;
        case (rm_i)
            `FXD_RM_NEAREST: to_inf = 1'b1;
            `FXD_RM_ZERO: to_inf = 1'b0;
            `FXD_RM_PLUS: to_inf = ~sign_i;
            default: to_inf = sign_i;
        endcase
        if (invalid_i)
            res_o = dbl_i ? `FXD_QNAN_D : `FXD_QNAN_S;
        else if (divz_i)
            res_o = inf_v | sgn_v;
        else if (over_i)
            res_o = (to_inf ? inf_v : maxf_v) | sgn_v;
        else
            res_o = res_i;
    end
endmodule // fxd_default

`default_nettype wire

// ==== core/fxd_top.v ====
// Exception detect block: per-operation conditions, default results and the
// control/status word.
// Assumes one datapath operation per op_valid_i pulse with its results,
// exponent and exactness inputs, and an Avalon-MM master that
// holds each request until waitrequest is low.
`timescale 1ns/10ps
`default_nettype none
`include "fxd_defs.vh"

module fxd_top #(
    parameter SNAN_WHEN_SET = 1
) (
    input wire clk_i,
    input wire rst_i,
    // Avalon-MM slave.
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Datapath operation side.
    input wire op_valid_i,
    input wire [3:0] op_code_i,
    input wire op_dbl_i,
    input wire [63:0] opa_i,
    input wire [63:0] opb_i,
    input wire [63:0] res_i,
    input wire res_sign_i,
    input wire res_nonzero_i,
    input wire signed [12:0] res_exp_i,
    input wire res_exact_i,
    input wire deliv_exact_i,
    input wire cvt_overflow_i,
    input wire cmp_signaling_i,
    input wire unimpl_i,
    // Results toward the register file and the trap logic.
    output wire done_o,
    output wire [63:0] result_o,
    output wire [5:0] cond_vec_o,
    output wire trap_o,
    output wire [1:0] rounding_mode_o
);
    // ------------------------------------------------------------------
    // Operand classification
    // ------------------------------------------------------------------
    wire a_sign;
    wire a_zero;
    wire a_inf;
    wire a_nan;
    wire a_snan;
    wire b_sign;
    wire b_zero;
    wire b_inf;
    wire b_nan;
    wire b_snan;

    fxd_classify #(
        .SNAN_WHEN_SET(SNAN_WHEN_SET)
    ) u_cls_a (
        .val_i(opa_i),
        .dbl_i(op_dbl_i),
        .sign_o(a_sign),
        .zero_o(a_zero),
        .inf_o(a_inf),
        .nan_o(a_nan),
        .snan_o(a_snan)
    );

    fxd_classify #(
        .SNAN_WHEN_SET(SNAN_WHEN_SET)
    ) u_cls_b (
        .val_i(opb_i),
        .dbl_i(op_dbl_i),
        .sign_o(b_sign),
        .zero_o(b_zero),
        .inf_o(b_inf),
        .nan_o(b_nan),
        .snan_o(b_snan)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [1:0] rm_r;
    reg [4:0] flag_r;
    reg [4:0] en_r;
    reg [5:0] cause_r;
    reg imprecise_r;
    reg [31:0] rdata_r;
    reg wait_r;
    reg done_r;
    reg [63:0] result_r;
    reg [5:0] cond_r;
    reg trap_r;

    // ------------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------------
    wire is_add;
    wire is_sub;
    wire is_mul;
    wire is_div;
    wire is_sqrt;
    wire is_cmp;
    wire is_cvtf;
    wire is_cvti;
    wire is_quiet_op;
    wire is_arith;
    wire fp_result;
    wire unb_b_sign;

    // Moves and transfers raise no condition.
    assign is_add = (op_code_i == `FXD_OP_ADD);
    assign is_sub = (op_code_i == `FXD_OP_SUB);
    assign is_mul = (op_code_i == `FXD_OP_MUL);
    assign is_div = (op_code_i == `FXD_OP_DIV);
    assign is_sqrt = (op_code_i == `FXD_OP_SQRT);
    assign is_cmp = (op_code_i == `FXD_OP_CMP);
    assign is_cvtf = (op_code_i == `FXD_OP_CVTF);
    assign is_cvti = (op_code_i == `FXD_OP_CVTI);
    assign is_quiet_op = (op_code_i == `FXD_OP_MOVE) | (op_code_i == `FXD_OP_XFER);
    assign is_arith = ~is_quiet_op;
    assign fp_result = is_add | is_sub | is_mul | is_div | is_sqrt | is_cvtf;
    // Subtraction flips the second sign before the infinity sign test.
    assign unb_b_sign = is_sub ? ~b_sign : b_sign;

    // ------------------------------------------------------------------
    // Invalid operation and divide by zero
    // ------------------------------------------------------------------
    wire any_nan;
    wire inv_snan;
    wire inv_inf_sub;
    wire inv_mul;
    wire inv_div;
    wire inv_sqrt;
    wire inv_cvt;
    wire inv_cmp;
    wire det_invalid;
    wire det_divz;

    // Each source of invalid operation is checked on its own.
    assign any_nan = a_nan | b_nan;
    assign inv_snan = is_arith & (a_snan | b_snan);
    assign inv_inf_sub = (is_add | is_sub) & a_inf & b_inf & (a_sign != unb_b_sign);
    assign inv_mul = is_mul & ((a_zero & b_inf) | (a_inf & b_zero));
    assign inv_div = is_div & ((a_zero & b_zero) | (a_inf & b_inf));
    assign inv_sqrt = is_sqrt & a_sign & ~a_zero & ~a_nan;
    assign inv_cvt = is_cvti & (cvt_overflow_i | a_inf | a_nan);
    assign inv_cmp = is_cmp & any_nan & cmp_signaling_i;
    assign det_invalid = inv_snan | inv_inf_sub | inv_mul | inv_div | inv_sqrt | inv_cvt
        | inv_cmp;
    // Infinity over zero and zero over zero stay clear of this condition.
    assign det_divz = is_div & b_zero & ~a_zero & ~a_inf & ~a_nan;

    // ------------------------------------------------------------------
    // Overflow, underflow and inexact
    // ------------------------------------------------------------------
    wire special_in;
    wire range_ok;
    wire signed [12:0] emax;
    wire signed [12:0] emin;
    wire det_over;
    wire tiny;
    wire acc_loss;
    wire det_under;
    wire det_inexact;

    // Range conditions only apply to a finite, computed floating result.
    assign special_in = any_nan | a_inf | (b_inf & ~is_sqrt & ~is_cvtf);
    assign range_ok = fp_result & ~special_in & ~det_invalid & ~det_divz;
    assign emax = op_dbl_i ? `FXD_EMAX_D : `FXD_EMAX_S;
    assign emin = op_dbl_i ? `FXD_EMIN_D : `FXD_EMIN_S;
    assign det_over = range_ok & res_nonzero_i & (res_exp_i > emax);
    assign tiny = range_ok & res_nonzero_i & (res_exp_i < emin);
    assign acc_loss = ~deliv_exact_i;
    // The enable decides whether accuracy loss is needed as well.
    assign det_under = en_r[`FXD_C_UNDER] ? tiny : (tiny & acc_loss);
    // Inexact may ride along with overflow or underflow, never with the others.
    assign det_inexact = ((range_ok | (is_cvti & ~inv_cvt)) & ~res_exact_i)
        | (det_over & ~en_r[`FXD_C_OVER]);

    // ------------------------------------------------------------------
    // Condition vector and trap decision
    // ------------------------------------------------------------------
    reg [5:0] op_cond;
    wire op_trap;
    wire op_done;

    // Unimplemented suppresses the IEEE conditions; transfers raise nothing.
    always @*
    begin
        op_cond = 6'h00;
        if (unimpl_i & is_arith)
        begin
            op_cond[`FXD_C_UNIMPL] = 1'b1;
        end
        else if (is_arith)
        begin
            op_cond[`FXD_C_INVALID] = det_invalid;
            op_cond[`FXD_C_DIVZ] = det_divz;
            op_cond[`FXD_C_OVER] = det_over;
            op_cond[`FXD_C_UNDER] = det_under;
            op_cond[`FXD_C_INEXACT] = det_inexact;
        end
    end

    // Unimplemented always traps, the others only when enabled.
    assign op_trap = op_cond[`FXD_C_UNIMPL] | (|(op_cond[4:0] & en_r));
    assign op_done = op_valid_i;

    // ------------------------------------------------------------------
    // Default result
    // ------------------------------------------------------------------
    wire [63:0] dflt_res;
    wire dflt_sign;

    assign dflt_sign = is_div ? (a_sign ^ b_sign) : res_sign_i;

    fxd_default u_dflt (
        .res_i(res_i),
        .dbl_i(op_dbl_i),
        .sign_i(dflt_sign),
        .rm_i(rm_r),
        .invalid_i(op_cond[`FXD_C_INVALID]),
        .divz_i(op_cond[`FXD_C_DIVZ] | (is_div & a_inf & b_zero)),
        .over_i(op_cond[`FXD_C_OVER] & ~en_r[`FXD_C_OVER]),
        .res_o(dflt_res)
    );

    // ------------------------------------------------------------------
    // Operation outputs
    // ------------------------------------------------------------------
    // Result and condition vector leave in the same cycle.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            done_r <= 1'b0;
            result_r <= 64'h0;
            cond_r <= 6'h00;
        end
        else
        begin
            done_r <= op_done;
            if (op_done)
            begin
                result_r <= dflt_res;
                cond_r <= op_cond;
            end
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave and control/status word
    // ------------------------------------------------------------------
    wire bus_req;
    wire bus_fire;
    wire wr_csw;
    wire [31:0] csw_view;
    wire [31:0] wdata_m;
    wire [5:0] wr_cause;
    wire [4:0] wr_flag;
    wire [4:0] wr_en;
    wire flags_take;
    reg [5:0] cause_nxt;
    reg [4:0] flag_nxt;
    reg [4:0] en_nxt;

    // Requests are answered one cycle after they are first seen.
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_fire = bus_req & ~wait_r;
    assign wr_csw = bus_fire & avs_write_i & (avs_address_i == `FXD_ADDR_CSW);
    // Byte enables merge the write into the present word.
    assign wdata_m = {
        avs_byteenable_i[3] ? avs_writedata_i[31:24] : csw_view[31:24],
        avs_byteenable_i[2] ? avs_writedata_i[23:16] : csw_view[23:16],
        avs_byteenable_i[1] ? avs_writedata_i[15:8] : csw_view[15:8],
        avs_byteenable_i[0] ? avs_writedata_i[7:0] : csw_view[7:0]
    };
    assign wr_cause = wdata_m[`FXD_CSW_CAUSE_LSB+5:`FXD_CSW_CAUSE_LSB];
    assign wr_flag = wdata_m[`FXD_CSW_FLAG_LSB+4:`FXD_CSW_FLAG_LSB];
    assign wr_en = wdata_m[`FXD_CSW_EN_LSB+4:`FXD_CSW_EN_LSB];
    assign csw_view = {7'h00, imprecise_r, 6'h00, cause_r, en_r, flag_r, rm_r};
    // Precise mode keeps flags for completing operations only.
    assign flags_take = op_done & (imprecise_r | ~op_trap);

    // Next cause, enable and flag values; an operation cause wins over a written one, operation flags are ORed into written flags.
    always @*
    begin
        cause_nxt = cause_r;
        en_nxt = en_r;
        flag_nxt = flag_r;
        if (wr_csw)
        begin
            cause_nxt = wr_cause;
            en_nxt = wr_en;
            flag_nxt = wr_flag;
            if (imprecise_r)
                flag_nxt = wr_flag | wr_cause[4:0];
        end
        if (op_done)
            cause_nxt = op_cond;
        if (flags_take)
            flag_nxt = flag_nxt | op_cond[4:0];
    end

    // Register file state, bus handshake and trap output.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rm_r <= 2'h0;
            flag_r <= 5'h00;
            en_r <= 5'h00;
            cause_r <= 6'h00;
            imprecise_r <= 1'b0;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
            trap_r <= 1'b0;
        end
        else
        begin
            cause_r <= cause_nxt;
            en_r <= en_nxt;
            flag_r <= flag_nxt;
            if (wr_csw)
            begin
                rm_r <= wdata_m[`FXD_CSW_RM_LSB+1:`FXD_CSW_RM_LSB];
                imprecise_r <= wdata_m[`FXD_CSW_IMPRECISE];
            end
            // A written cause with its enable set traps too.
            trap_r <= cause_nxt[`FXD_C_UNIMPL] | (|(cause_nxt[4:0] & en_nxt));
            if (bus_req & wait_r)
            begin
                wait_r <= 1'b0;
                case (avs_address_i)
                    `FXD_ADDR_CSW: rdata_r <= csw_view;
                    `FXD_ADDR_STATUS: rdata_r <= {24'h0, trap_r, done_r, cond_r};
                    default: rdata_r <= 32'h0;
                endcase
            end
            else
            begin
                wait_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output wiring
    // ------------------------------------------------------------------
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign done_o = done_r;
    assign result_o = result_r;
    assign cond_vec_o = cond_r;
    assign trap_o = trap_r;
    assign rounding_mode_o = rm_r;
endmodule // fxd_top

`default_nettype wire

// ==== testbench/fxd_top_asserts.sv ====
// Port-level checker for the exception detect block.
// Assumes binding into fxd_top and fxd_defs.vh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "fxd_defs.vh"

module fxd_top_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire avs_waitrequest_o,
    input wire op_valid_i,
    input wire [3:0] op_code_i,
    input wire unimpl_i,
    input wire done_o,
    input wire [5:0] cond_vec_o,
    input wire trap_o,
    input wire [1:0] rounding_mode_o
);
    // -----------------------------------------------------------
    // Properties
    // -----------------------------------------------------------
    // All checks share the one clock and its reset.
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_done_follows: assert property (op_valid_i |=> done_o)
        else $error("Done missing.");
    a_done_single: assert property (!op_valid_i |=> !done_o)
        else $error("Stray done.");
    a_move_quiet: assert property (op_valid_i && !unimpl_i &&
        (op_code_i == `FXD_OP_MOVE || op_code_i == `FXD_OP_XFER) |=> cond_vec_o == 6'h00)
        else $error("Transfer condition.");
    a_unimpl_trap: assert property (op_valid_i && unimpl_i |=>
        cond_vec_o == 6'h20 && trap_o)
        else $error("Unimplemented not alone.");
    a_one_cond: assert property (done_o |-> $onehot0(cond_vec_o[5:1]) &&
        !(cond_vec_o[0] && |cond_vec_o[5:3]))
        else $error("Bad condition mix.");
    a_over_inexact: assert property (done_o && cond_vec_o[2] && !trap_o |-> cond_vec_o[0])
        else $error("Overflow without inexact.");
    a_no_cause_trap: assert property (done_o && cond_vec_o == 6'h00 |-> !trap_o)
        else $error("Trap without cause.");
    a_wait_once: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("Late bus answer.");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("Long wait low.");
    a_rm_written: assert property (avs_write_i && !avs_waitrequest_o &&
        avs_address_i == `FXD_ADDR_CSW && avs_byteenable_i[0] |=>
        rounding_mode_o == $past(avs_writedata_i[1:0]))
        else $error("Mode not written.");
endmodule // fxd_top_asserts

bind fxd_top fxd_top_asserts fxd_top_asserts_inst (.*);
`default_nettype wire

// ==== testbench/fxd_dp_model.sv ====
// Datapath stand-in: one single-precision operation per call.
// Assumes a free-running clock.
`timescale 1ns/10ps
`default_nettype none

module fxd_dp_model (
    input wire logic clk_i,
    output logic op_valid_o,
    output logic [3:0] op_code_o,
    output logic op_dbl_o,
    output logic [63:0] opa_o,
    output logic [63:0] opb_o,
    output logic [63:0] res_o,
    output logic res_sign_o,
    output logic res_nonzero_o,
    output logic signed [12:0] res_exp_o,
    output logic res_exact_o,
    output logic deliv_exact_o,
    output logic cvt_overflow_o,
    output logic cmp_signaling_o,
    output logic unimpl_o
);
    // Quiet outputs until the first operation.
    initial
    begin
        {op_valid_o, op_code_o, op_dbl_o, opa_o, opb_o, res_o, res_sign_o} = '0;
        {res_nonzero_o, res_exp_o, res_exact_o, deliv_exact_o} = '0;
        {cvt_overflow_o, cmp_signaling_o, unimpl_o} = '0;
    end

    // Flags f are {unimplemented, signaling compare, convert overflow, exact}.
    task automatic issue(input logic [3:0] c, input logic [31:0] a, b, r,
                         input logic signed [12:0] e, input logic [3:0] f);
        @(posedge clk_i);
        op_valid_o <= 1'b1;
        op_code_o <= c;
        opa_o <= {32'h0, a};
        opb_o <= {32'h0, b};
        res_o <= {32'h0, r};
        res_sign_o <= r[31];
        res_nonzero_o <= |r[30:0];
        res_exp_o <= e;
        {unimpl_o, cmp_signaling_o, cvt_overflow_o, res_exact_o} <= f;
        deliv_exact_o <= f[0];
        @(posedge clk_i);
        op_valid_o <= 1'b0;
        opa_o <= ~opa_o;
        opb_o <= ~opb_o;
        res_o <= ~res_o;
    endtask
endmodule // fxd_dp_model
`default_nettype wire

// ==== testbench/fxd_top_tb.sv ====
// Self-checking bench for the exception detect block.
// Assumes the datapath model and checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
`include "fxd_defs.vh"

module fxd_top_tb;
    // -----------------------------------------------------------
    // Signals and instances
    // -----------------------------------------------------------
    logic clk_i, rst_i, avs_read_i, avs_write_i;
    logic [3:0] avs_address_i, avs_byteenable_i, lanes;
    logic [31:0] avs_writedata_i;
    logic [4:0] en;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, op_valid_i, op_dbl_i, res_sign_i, res_nonzero_i, res_exact_i;
    wire deliv_exact_i, cvt_overflow_i, cmp_signaling_i, unimpl_i, done_o, trap_o;
    wire [3:0] op_code_i;
    wire [63:0] opa_i, opb_i, res_i, result_o;
    wire signed [12:0] res_exp_i;
    wire [5:0] cond_vec_o;
    wire [1:0] rounding_mode_o;
    int errors, checked, cycles;

    fxd_dp_model fxd_dp_model_inst (.clk_i(clk_i), .op_valid_o(op_valid_i),
        .op_code_o(op_code_i), .op_dbl_o(op_dbl_i), .opa_o(opa_i), .opb_o(opb_i),
        .res_o(res_i), .res_sign_o(res_sign_i), .res_nonzero_o(res_nonzero_i),
        .res_exp_o(res_exp_i), .res_exact_o(res_exact_i), .deliv_exact_o(deliv_exact_i),
        .cvt_overflow_o(cvt_overflow_i), .cmp_signaling_o(cmp_signaling_i),
        .unimpl_o(unimpl_i));
    fxd_top fxd_top_inst (.*);

    // -----------------------------------------------------------
    // Bus, compare and operation tasks
    // -----------------------------------------------------------
    task cmp(input string n, input logic [63:0] e, g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {avs_address_i, avs_writedata_i, avs_byteenable_i} <= {a, d, lanes};
        avs_write_i <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        if (a == `FXD_ADDR_CSW && lanes[1]) en = d[11:7];
    endtask

    task bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask

    // Result lands one edge after the operation.
    task chk_op(input logic [3:0] c, input logic [31:0] a, b, r,
                          input logic signed [12:0] e, input logic [3:0] f,
                          input logic [5:0] ec, input logic [63:0] er);
        fxd_dp_model_inst.issue(c, a, b, r, e, f);
        #1;
        cmp("done", 1'b1, done_o);
        cmp("cond", ec, cond_vec_o);
        cmp("trap", ec[5] | |(ec[4:0] & en), trap_o);
        if (ec != 6'h20) cmp("result", er, result_o);
    endtask

    task inv(input logic [3:0] c, input logic [31:0] a, b, input logic [3:0] f);
        chk_op(c, a, b, 0, 0, f, 6'h10, `FXD_QNAN_S);
    endtask

    task add1(input logic [31:0] b, r, input logic signed [12:0] e, input logic [3:0] f,
              input logic [5:0] ec);
        chk_op(`FXD_OP_ADD, 32'h3f800001, b, r, e, f, ec, r);
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task t_reset;
        logic [31:0] d;
        bus_rd(`FXD_ADDR_CSW, d);
        cmp("csw reset", `FXD_CSW_RESET, d);
        bus_wr(4'h8, 32'hffffffff);
        bus_rd(4'h8, d);
        cmp("unmapped", 0, d);
        lanes = 4'he;
        bus_wr(`FXD_ADDR_CSW, 32'h3);
        lanes = 4'hf;
        #1 cmp("lane off", 0, rounding_mode_o);
    endtask

    task t_overflow;
        logic [63:0] x;
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                x = (m == 0 || m == 2 && s == 0 || m == 3 && s == 1) ? `FXD_INF_S : `FXD_MAXF_S;
                if (s == 1) x = x | `FXD_SIGN_S;
                bus_wr(`FXD_ADDR_CSW, m);
                chk_op(`FXD_OP_MUL, {s[0], 31'h7f000000}, 32'h40000000, {s[0], 31'h7f7fffff},
                       128, 0, 6'h05, x);
                cmp("mode", m, rounding_mode_o);
            end
        chk_op(`FXD_OP_MUL, 32'h7f000000, 32'h3fffffff, 32'h7f7fffff, 127, 0, 6'h01, `FXD_MAXF_S);
    endtask

    task t_invalid;
        inv(`FXD_OP_ADD, 32'h7fc00000, 32'h3f800000, 1);
        inv(`FXD_OP_ADD, 32'h7f800000, 32'hff800000, 1);
        inv(`FXD_OP_SUB, 32'hff800000, 32'hff800000, 1);
        inv(`FXD_OP_MUL, 32'h80000000, 32'h7f800000, 1);
        inv(`FXD_OP_DIV, 32'h80000000, 32'h00000000, 1);
        inv(`FXD_OP_DIV, 32'hff800000, 32'h7f800000, 1);
        inv(`FXD_OP_SQRT, 32'hbf800000, 0, 1);
        chk_op(`FXD_OP_SQRT, 32'h80000000, 0, 32'h80000000, 0, 1, 6'h00, 32'h80000000);
        inv(`FXD_OP_CVTI, 32'h4f800000, 0, 4'h3);
        inv(`FXD_OP_CVTI, 32'h7f800000, 0, 1);
        inv(`FXD_OP_CMP, 32'h7f800001, 32'h3f800000, 4'h5);
        chk_op(`FXD_OP_CMP, 32'h7f800001, 32'h3f800000, 0, 0, 1, 6'h00, 0);
        chk_op(`FXD_OP_MOVE, 32'h7fc00000, 0, 32'h7fc00000, 0, 1, 6'h00, 32'h7fc00000);
        chk_op(`FXD_OP_XFER, 32'h7fc00000, 0, 32'h7fc00000, 0, 1, 6'h00, 32'h7fc00000);
    endtask

    task t_divz;
        chk_op(`FXD_OP_DIV, 32'h3f800000, 0, 32'h7f800000, 0, 1, 6'h08, `FXD_INF_S);
        chk_op(`FXD_OP_DIV, 32'hbf800000, 0, 32'hff800000, 0, 1, 6'h08,
               `FXD_INF_S | `FXD_SIGN_S);
        chk_op(`FXD_OP_DIV, 32'h7f800000, 0, 32'h7f800000, 0, 1, 6'h00, `FXD_INF_S);
    endtask

    task t_under;
        add1(32'hbf800000, 32'h00800000, -127, 0, 6'h03);
        add1(32'hbf800000, 32'h00400000, -127, 1, 6'h00);
        add1(32'hbf800000, 32'h00800000, -126, 0, 6'h01);
        bus_wr(`FXD_ADDR_CSW, 32'h100);
        add1(32'hbf800000, 32'h00400000, -127, 1, 6'h02);
        bus_wr(`FXD_ADDR_CSW, 0);
    endtask

    task t_unimpl;
        chk_op(`FXD_OP_SQRT, 32'h3f800000, 0, 32'h3f800000, 0, 4'h9, 6'h20, 0);
        chk_op(`FXD_OP_MUL, 32'h7f000000, 32'h40000000, 0, 128, 4'h8, 6'h20, 0);
    endtask

    task t_flags;
        logic [31:0] d;
        bus_wr(`FXD_ADDR_CSW, 32'h80);
        add1(32'h33800000, 32'h3f800000, 0, 0, 6'h01);
        bus_rd(`FXD_ADDR_CSW, d);
        cmp("csw trapped", 32'h1080, d);
        bus_wr(`FXD_ADDR_CSW, 0);
        #1 cmp("trap cleared", 0, trap_o);
        add1(32'h33800000, 32'h3f800000, 0, 0, 6'h01);
        bus_rd(`FXD_ADDR_CSW, d);
        cmp("csw flags", 32'h1004, d);
        bus_wr(`FXD_ADDR_CSW, 32'h1080);
        #1 cmp("trap on write", 1, trap_o);
        bus_rd(`FXD_ADDR_STATUS, d);
        cmp("status", 32'h81, d);
        bus_wr(`FXD_ADDR_CSW, 0);
    endtask

    task wrap_up;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // -----------------------------------------------------------
    // Clock, timeout and main sequence
    // -----------------------------------------------------------
    // Free-running 250 MHz clock.
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Ends a hung run.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            wrap_up;
        end
    end

    // Reset, then every scenario in turn.
    initial
    begin
        rst_i = 1'b1;
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'hf;
        lanes = 4'hf;
        en = 5'h00;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_overflow;
        t_invalid;
        t_divz;
        t_under;
        t_unimpl;
        t_flags;
        wrap_up;
    end
endmodule // fxd_top_tb
`default_nettype wire
